// ==== testbench/flash_block_write_protect_ctrl_bench.sv ====
// bench: both flash ends joined, driven over the avalon registers
// assumes package, interface and design modules compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module flash_block_write_protect_ctrl_bench;
  import flash_pkg::*;
  logic mclk, srst, jtag_req, jtag_gnt, avs_read, avs_write, avs_waitrequest, irq;
  logic [RA_W+1:0] avs_address;
  logic [DATA_W-1:0] avs_writedata, avs_readdata, rd;
  logic [1:0] st, ist;
  int bad_count, comparisons;
  flash_if fl();
  flash_block i_flash_block(.mclk, .srst, .fl(fl), .jtag_req, .jtag_gnt);
  flash_ctrl i_flash_ctrl(.mclk, .srst, .fl(fl), .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .irq);
  flash_link_sva i_flash_link_sva(.mclk, .srst, .op_req(fl.op_req),
    .access_width_sel(fl.access_width_sel), .write_data_bus(fl.write_data_bus),
    .status(fl.status), .busy(fl.busy), .done(fl.done),
    .user_access_hold(fl.user_access_hold), .jtag_req, .jtag_gnt);
  // ****
  // tasks
  // ****
  task automatic close_out();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  // hold the request until waitrequest is seen low at an edge
  // no local limit: only the watchdog ends a hung wait
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  // f = {hold, write guard, keep guard}
  task automatic op(input logic [7:0] o, input logic [8:0] a, input logic [31:0] d,
    input logic [1:0] w, input logic [2:0] f);
    bus(1'b1, 5'h04, {23'h0, a});
    bus(1'b1, 5'h08, d);
    bus(1'b1, 5'h00, {18'h0, w, 1'b0, f, o});
    do begin
      bus(1'b0, 5'h14, '0);
    end while (rd[IRQ_DONE] !== 1'b1);
    ist = rd[1:0];
    bus(1'b0, 5'h10, '0);
    st = rd[1:0];
    bus(1'b1, 5'h14, 32'h0000_0003);
  endtask : op
  task automatic rdchk(input logic [8:0] a, input logic [1:0] w, input logic [31:0] e);
    op(8'h04, a, '0, w, 3'h0);
    bus(1'b0, 5'h0C, '0);
    `CHK(rd, e)
  endtask : rdchk
  // ****
  // clock, reset, watchdog
  // ****
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    repeat (30000) @(posedge mclk);
    bad_count++;
    close_out();
  end
  // ****
  // tests
  // ****
  initial begin
    srst = 1'b1;
    jtag_req = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    bad_count = 0;
    comparisons = 0;
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    op(8'h10, 9'h000, '0, 2'h2, 3'h0);
    op(8'h10, 9'h080, '0, 2'h2, 3'h0);
    rdchk(9'h000, 2'h2, 32'hFFFF_FFFF);
    // widths and masking; the controller trims write data to width
    op(8'h08, 9'h003, 32'hFFFF_FF5A, 2'h0, 3'h0);
    `CHK(st, ST_OK)
    op(8'h08, 9'h005, 32'h0000_1234, 2'h1, 3'h0);
    op(8'h08, 9'h00B, 32'h89AB_CDEF, 2'h2, 3'h0);
    op(8'h08, 9'h07F, 32'h1357_9BDF, 2'h3, 3'h0);
    rdchk(9'h000, 2'h2, 32'h5AFF_FFFF);
    rdchk(9'h004, 2'h2, 32'hFFFF_1234);
    rdchk(9'h008, 2'h2, 32'h89AB_CDEF);
    rdchk(9'h003, 2'h0, 32'h0000_005A);
    rdchk(9'h005, 2'h1, 32'h0000_1234);
    rdchk(9'h07C, 2'h2, 32'h1357_9BDF);
    // page keep guard
    op(8'h08, 9'h080, 32'h0000_0001, 2'h0, 3'h1);
    `CHK(st, ST_KGUARD)
    `CHK(ist, 2'h3)
    rdchk(9'h080, 2'h2, 32'hFFFF_FFFF);
    op(8'h08, 9'h000, 32'h0000_0011, 2'h0, 3'h1);
    `CHK(st, ST_OK)
    // overwrite guard: set, refuse, remove
    op(8'h20, 9'h000, '0, 2'h2, 3'h2);
    `CHK(st, ST_OK)
    for (int i = 0; i < 3; i++) begin
      op(8'h08 << i, 9'h000, '0, 2'h0, 3'h0);
      `CHK(st, ST_WGUARD)
    end
    rdchk(9'h000, 2'h2, 32'h5AFF_FF11);
    op(8'h40, 9'h000, '0, 2'h2, 3'h0);
    op(8'h20, 9'h000, '0, 2'h2, 3'h0);
    op(8'h10, 9'h000, '0, 2'h2, 3'h0);
    `CHK(st, ST_OK)
    rdchk(9'h000, 2'h2, 32'hFFFF_FFFF);
    // discard lifts the keep guard
    op(8'h08, 9'h000, 32'h0000_0022, 2'h0, 3'h1);
    op(8'h80, 9'h000, '0, 2'h0, 3'h1);
    op(8'h08, 9'h080, 32'h0000_0077, 2'h0, 3'h1);
    `CHK(st, ST_OK)
    // read beats write and erase in the same request
    op(8'h1C, 9'h080, 32'h0000_0055, 2'h0, 3'h0);
    bus(1'b0, 5'h0C, '0);
    `CHK(rd, 32'h0000_0077)
    rdchk(9'h080, 2'h0, 32'h0000_0077);
    op(8'h03, 9'h080, '0, 2'h0, 3'h0);
    op(8'h02, 9'h080, '0, 2'h0, 3'h0);
    rdchk(9'h080, 2'h0, 32'h0000_00FF);
    // jtag held off by the user side
    // register writes land at the accepting edge, so look one edge later
    bus(1'b1, 5'h00, 32'h0000_0400);
    @(posedge mclk);
    `CHK(jtag_gnt, 1'b0)
    bus(1'b1, 5'h00, '0);
    @(posedge mclk);
    `CHK(jtag_gnt, 1'b1)
    jtag_req <= 1'b0;
    @(posedge mclk);
    `CHK(jtag_gnt, 1'b0)
    // interrupt raise, mask, clear; unmapped word reads zero
    bus(1'b1, 5'h00, 32'h0000_0004);
    bus(1'b1, 5'h18, '0);
    @(posedge mclk);
    `CHK(irq, 1'b0)
    bus(1'b1, 5'h18, 32'h0000_0003);
    @(posedge mclk);
    `CHK(irq, 1'b1)
    bus(1'b1, 5'h14, 32'h0000_0003);
    @(posedge mclk);
    `CHK(irq, 1'b0)
    bus(1'b1, 5'h18, '0);
    bus(1'b0, 5'h1C, '0);
    `CHK(rd, 32'h0000_0000)
    close_out();
  end
endmodule : flash_block_write_protect_ctrl_bench

// ==== testbench/flash_link_sva.sv ====
// checker of the link between the flash block and its controller
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
module flash_link_sva
  import flash_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [NOPS-1:0] op_req,
  input wire logic [1:0] access_width_sel,
  input wire logic [DATA_W-1:0] write_data_bus,
  input wire logic [1:0] status,
  input wire logic busy,
  input wire logic done,
  input wire logic user_access_hold,
  input wire logic jtag_req,
  input wire logic jtag_gnt
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  logic take;
  assign take = !busy && (op_req != '0);
  // lowest set bit wins, so a write only counts with bits 2:0 clear
  sequence wr_take;
    take && op_req[2:0] == 3'h0 && op_req[OP_WRITE];
  endsequence
  sequence fast_take;
    take && !(op_req[2:0] == 3'h0 && op_req[OP_WRITE]);
  endsequence
  hold_stall_a: assert property (user_access_hold |-> !jtag_gnt)
    else $error("jtag granted during hold");
  busy_stall_a: assert property (busy || op_req != '0 |-> !jtag_gnt)
    else $error("jtag granted while busy");
  gnt_free_a: assert property (jtag_req && !user_access_hold && !busy && op_req == '0
    |-> jtag_gnt)
    else $error("jtag not granted when free");
  fast_done_a: assert property (fast_take |=> done)
    else $error("short op not done next cycle");
  write_done_a: assert property (wr_take |-> ##[1:5] done)
    else $error("write not done in time");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
  req_drop_a: assert property (done |=> op_req == '0)
    else $error("request held past done");
  byte_zero_a: assert property (op_req[OP_WRITE] && access_width_sel == WID_1B
    |-> write_data_bus[31:8] == '0)
    else $error("byte write data not zeroed");
  half_zero_a: assert property (op_req[OP_WRITE] && access_width_sel == WID_2B
    |-> write_data_bus[31:16] == '0)
    else $error("half write data not zeroed");
  status_code_a: assert property (status != 2'h2)
    else $error("undefined status code");
endmodule : flash_link_sva

// ==== verilog/flash_block.sv ====
// flash block end: array, page buffer, block buffer, guards and jtag arbitration
// assumes requests are held until done and synchronous to mclk
// How it works
// - write to unbuffered page loads whole page first
// - addressed block into block buffer, then overwritten
// - block buffer copied back into page buffer
// - same-block writes update both buffers directly
// - other block loaded from page buffer first
// - two-bit selector picks one, two, four bytes
// - low address bits ignored for wider widths
// - user zeroes write data above width
// - page-keep guard refuses writes to other pages
// - such refusal reports status 11, or 01 when the addressed page is also guarded
// - write/program/erase of guarded page gives 01
// - program with guard input marks page guarded
// - unprotect then unguarded program removes guard
// - user hold stalls every jtag access
// - of simultaneous operations only the lowest-index one is served
// - page buffer holds eight blocks
// - block buffer holds one 128-bit block
//
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/1ps
module flash_block
  import flash_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  flash_if.dev fl,
  input wire logic jtag_req,
  output logic jtag_gnt
);

  typedef enum logic [2:0] {S_IDLE, S_PGLOAD, S_BLKLOAD, S_MERGE, S_SYNC, S_DONE} state_t;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [2:0] pick_op(input logic [NOPS-1:0] req);
    logic [2:0] r;
    r = 3'h0;
    for (int i = NOPS - 1; i >= 0; i--) begin
      if (req[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : pick_op

  function automatic int nbytes(input logic [1:0] w);
    return (w == WID_1B) ? 1 : (w == WID_2B) ? 2 : 4;
  endfunction : nbytes

  function automatic logic [BYTE_W-1:0] byte_off(input logic [BYTE_W-1:0] a,
                                                 input logic [1:0] w);
    logic [BYTE_W-1:0] m;
    m = (w == WID_1B) ? a : (w == WID_2B) ? {a[BYTE_W-1:1], 1'b0} : {a[BYTE_W-1:2], 2'h0};
    return m;
  endfunction : byte_off

  function automatic logic [BLK_BITS-1:0] merge(input logic [BLK_BITS-1:0] b,
      input logic [BYTE_W-1:0] off, input logic [1:0] w, input logic [DATA_W-1:0] d);
    logic [BLK_BITS-1:0] r;
    r = b;
    for (int i = 0; i < DATA_W / 8; i++) begin
      if (i < nbytes(w)) begin
        r[(int'(off) + i) * 8 +: 8] = d[i * 8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [DATA_W-1:0] extract(input logic [BLK_BITS-1:0] b,
      input logic [BYTE_W-1:0] off, input logic [1:0] w);
    logic [DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < DATA_W / 8; i++) begin
      if (i < nbytes(w)) begin
        r[i * 8 +: 8] = b[(int'(off) + i) * 8 +: 8];
      end
    end
    return r;
  endfunction : extract

  // ****************************************
  // storage
  // ****************************************
  logic [BLK_BITS-1:0] array_q [PAGES][BLOCKS];
  logic [BLK_BITS-1:0] pbuf_q [BLOCKS];
  logic [BLK_BITS-1:0] bbuf_q;
  logic [PAGE_W-1:0] cur_page_q;
  logic [BLK_W-1:0] cur_blk_q;
  logic pg_valid_q;
  logic blk_valid_q;
  logic [PAGES-1:0] wguard_q;
  logic [PAGES-1:0] unprot_q;

  state_t state_q;
  logic [2:0] op_q;
  logic [PAGE_W-1:0] page_q;
  logic [BLK_W-1:0] blk_q;
  logic [BYTE_W-1:0] off_q;
  logic [1:0] wid_q;
  logic [DATA_W-1:0] wdata_q;
  logic [1:0] status_q;
  logic [DATA_W-1:0] rdata_q;

  logic [PAGE_W-1:0] a_page;
  logic [BLK_W-1:0] a_blk;
  logic [2:0] op_sel;
  logic start;
  logic pg_hit;
  logic locked;
  logic keep_block;
  logic refuse;

  assign a_page = fl.addr[ADDR_W-1 -: PAGE_W];
  assign a_blk = fl.addr[BYTE_W +: BLK_W];
  assign op_sel = pick_op(fl.op_req);
  assign start = (state_q == S_IDLE) && (|fl.op_req);
  assign pg_hit = pg_valid_q && (cur_page_q == a_page);
  // unprotect only opens the door; the guard bit stays until the next program
  assign locked = wguard_q[a_page] && !unprot_q[a_page];
  assign keep_block = fl.page_keep_guard && pg_valid_q && !pg_hit;
  assign refuse = start && (((op_sel == 3'(OP_WRITE)) && (locked || keep_block))
    || (((op_sel == 3'(OP_ERASE)) || (op_sel == 3'(OP_PROGRAM))) && locked));

  // user traffic wins idle slots; jtag waits out any held lock
  assign jtag_gnt = jtag_req && !fl.user_access_hold && (state_q == S_IDLE)
    && !(|fl.op_req);

  assign fl.busy = (state_q != S_IDLE);
  assign fl.done = (state_q == S_DONE);
  assign fl.status = status_q;
  assign fl.read_data = rdata_q;

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= S_IDLE;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (start && !refuse && (op_sel == 3'(OP_WRITE))) begin
            if (!pg_hit) begin
              state_q <= S_PGLOAD;
            end else if (!blk_valid_q || (cur_blk_q != a_blk)) begin
              state_q <= S_BLKLOAD;
            end else begin
              state_q <= S_MERGE;
            end
          end else if (start) begin
            state_q <= S_DONE;
          end
        end
        S_PGLOAD: state_q <= S_BLKLOAD;
        S_BLKLOAD: state_q <= S_MERGE;
        S_MERGE: state_q <= S_SYNC;
        S_SYNC: state_q <= S_DONE;
        S_DONE: state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (start) begin
      op_q <= op_sel;
      page_q <= a_page;
      blk_q <= a_blk;
      off_q <= byte_off(fl.addr[BYTE_W-1:0], fl.access_width_sel);
      wid_q <= fl.access_width_sel;
      wdata_q <= fl.write_data_bus;
    end
  end

  // ****************************************
  // status and read data
  // ****************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      status_q <= ST_OK;
    end else if (start) begin
      if (refuse && keep_block && !locked) begin
        status_q <= ST_KGUARD;
      end else if (refuse) begin
        status_q <= ST_WGUARD;
      end else begin
        status_q <= ST_OK;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_q <= '0;
    end else if (start && (op_sel == 3'(OP_READ))) begin
      rdata_q <= extract(pg_hit ? pbuf_q[a_blk] : array_q[a_page][a_blk],
        byte_off(fl.addr[BYTE_W-1:0], fl.access_width_sel), fl.access_width_sel);
    end
  end

  // ****************************************
  // buffers
  // ****************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      pg_valid_q <= 1'b0;
      blk_valid_q <= 1'b0;
      cur_page_q <= '0;
      cur_blk_q <= '0;
    end else if (start && !refuse && ((op_sel == 3'(OP_INIT)) || (op_sel == 3'(OP_RESET))
        || (op_sel == 3'(OP_DISCARD)) || (op_sel == 3'(OP_PROGRAM) && pg_hit)
        || (op_sel == 3'(OP_ERASE) && pg_hit))) begin
      pg_valid_q <= 1'b0;
      blk_valid_q <= 1'b0;
    end else if (state_q == S_PGLOAD) begin
      pg_valid_q <= 1'b1;
      blk_valid_q <= 1'b0;
      cur_page_q <= page_q;
    end else if (state_q == S_BLKLOAD) begin
      blk_valid_q <= 1'b1;
      cur_blk_q <= blk_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (state_q == S_PGLOAD) begin
      pbuf_q <= array_q[page_q];
    end else if (state_q == S_SYNC) begin
      pbuf_q[blk_q] <= bbuf_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (state_q == S_BLKLOAD) begin
      bbuf_q <= pbuf_q[blk_q];
    end else if (state_q == S_MERGE) begin
      bbuf_q <= merge(bbuf_q, off_q, wid_q, wdata_q);
    end
  end

  // ****************************************
  // array and guards
  // ****************************************
  always_ff @(posedge mclk) begin
    if (start && !refuse && (op_sel == 3'(OP_ERASE))) begin
      for (int b = 0; b < BLOCKS; b++) begin
        array_q[a_page][b] <= ERASED;
      end
    end else if (start && !refuse && (op_sel == 3'(OP_PROGRAM)) && pg_hit) begin
      array_q[a_page] <= pbuf_q;
    end
  end

  // guard bits survive buffer resets; only srst, program and unprotect touch them
  always_ff @(posedge mclk) begin
    if (srst) begin
      wguard_q <= '0;
      unprot_q <= '0;
    end else if (start && !refuse && (op_sel == 3'(OP_PROGRAM))) begin
      wguard_q[a_page] <= fl.page_write_guard;
      unprot_q[a_page] <= 1'b0;
    end else if (start && (op_sel == 3'(OP_UNPROTECT))) begin
      unprot_q[a_page] <= 1'b1;
    end
  end

endmodule : flash_block

// ==== verilog/flash_ctrl.sv ====
// user-side controller: avalon-mm registers drive the flash link
// assumes one clock; one wait state on every bus access
`timescale 1ns/1ps
module flash_ctrl
  import flash_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  flash_if.usr fl,
  input wire logic [RA_W+1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);

  logic [NOPS-1:0] op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0] width_q;
  logic keep_q;
  logic wguard_q;
  logic hold_q;
  logic ack_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [DATA_W-1:0] readdata_q;
  logic [RA_W-1:0] ridx;
  logic wr;
  logic [IRQ_W-1:0] ev;

  function automatic logic [DATA_W-1:0] width_mask(input logic [1:0] w);
    return (w == WID_1B) ? 32'h0000_00ff : (w == WID_2B) ? 32'h0000_ffff : 32'hffff_ffff;
  endfunction : width_mask

  // ****************************************
  // bus slave
  // ****************************************
  assign ridx = avs_address[RA_W+1:2];
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign wr = avs_write && ack_q;
  assign avs_readdata = readdata_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      readdata_q <= '0;
    end else if (avs_read && !ack_q) begin
      case (ridx)
        REG_CTRL: readdata_q <= DATA_W'({width_q, 1'b0, hold_q, wguard_q, keep_q, op_q});
        REG_ADDR: readdata_q <= DATA_W'(addr_q);
        REG_WDATA: readdata_q <= wdata_q;
        REG_RDATA: readdata_q <= rdata_q;
        REG_STATUS: readdata_q <= DATA_W'({fl.busy || (|op_q), fl.status});
        REG_IRQ_STAT: readdata_q <= DATA_W'(irq_stat_q);
        REG_IRQ_MASK: readdata_q <= DATA_W'(irq_mask_q);
        default: readdata_q <= '0;
      endcase
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  // a new command is dropped while one is outstanding
  always_ff @(posedge mclk) begin
    if (srst) begin
      op_q <= '0;
      keep_q <= 1'b0;
      wguard_q <= 1'b0;
      hold_q <= 1'b0;
      width_q <= WID_1B;
    end else if (fl.done) begin
      op_q <= '0;
    end else if (wr && (ridx == REG_CTRL) && !(|op_q)) begin
      op_q <= avs_writedata[NOPS-1:0];
      keep_q <= avs_writedata[CTRL_KEEP];
      wguard_q <= avs_writedata[CTRL_WGUARD];
      hold_q <= avs_writedata[CTRL_HOLD];
      width_q <= avs_writedata[CTRL_WIDTH +: 2];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      addr_q <= '0;
      wdata_q <= '0;
    end else if (wr && (ridx == REG_ADDR)) begin
      addr_q <= avs_writedata[ADDR_W-1:0];
    end else if (wr && (ridx == REG_WDATA)) begin
      wdata_q <= avs_writedata;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_q <= '0;
    end else if (fl.done && op_q[OP_READ]) begin
      rdata_q <= fl.read_data;
    end
  end

  assign fl.op_req = op_q;
  assign fl.addr = addr_q;
  assign fl.access_width_sel = width_q;
  assign fl.write_data_bus = wdata_q & width_mask(width_q);
  assign fl.page_keep_guard = keep_q;
  assign fl.page_write_guard = wguard_q;
  assign fl.user_access_hold = hold_q;

  // ****************************************
  // interrupts
  // ****************************************
  assign ev = {fl.done && (fl.status != ST_OK), fl.done};

  // set beats the write-one clear in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_stat_q <= '0;
    end else if (wr && (ridx == REG_IRQ_STAT)) begin
      irq_stat_q <= (irq_stat_q & ~avs_writedata[IRQ_W-1:0]) | ev;
    end else begin
      irq_stat_q <= irq_stat_q | ev;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_mask_q <= '0;
    end else if (wr && (ridx == REG_IRQ_MASK)) begin
      irq_mask_q <= avs_writedata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

endmodule : flash_ctrl

// ==== verilog/flash_if.sv ====
// link between the flash block and the user-side controller
// assumes both ends share mclk
`timescale 1ns/1ps
interface flash_if;
  import flash_pkg::*;
  logic [NOPS-1:0] op_req;
  logic [ADDR_W-1:0] addr;
  logic [1:0] access_width_sel;
  logic [DATA_W-1:0] write_data_bus;
  logic [DATA_W-1:0] read_data;
  logic [1:0] status;
  logic busy;
  logic done;
  logic page_keep_guard;
  logic page_write_guard;
  logic user_access_hold;
  modport dev (input op_req, addr, access_width_sel, write_data_bus, page_keep_guard,
    page_write_guard, user_access_hold, output read_data, status, busy, done);
  modport usr (output op_req, addr, access_width_sel, write_data_bus, page_keep_guard,
    page_write_guard, user_access_hold, input read_data, status, busy, done);
endinterface : flash_if

// ==== verilog/flash_pkg.sv ====
// shared constants for the flash write path, its guards and the register front end
// assumes one clock domain; both ends import this package whole
package flash_pkg;
  localparam int PAGES = 4;
  localparam int PAGE_W = 2;
  localparam int BLOCKS = 8;
  localparam int BLK_W = 3;
  localparam int BLK_BITS = 128;
  localparam int BYTE_W = 4;
  localparam int ADDR_W = PAGE_W + BLK_W + BYTE_W;
  localparam int DATA_W = 32;
  localparam int NOPS = 8;
  // operation bit positions, lowest index wins
  localparam int OP_INIT = 0;
  localparam int OP_RESET = 1;
  localparam int OP_READ = 2;
  localparam int OP_WRITE = 3;
  localparam int OP_ERASE = 4;
  localparam int OP_PROGRAM = 5;
  localparam int OP_UNPROTECT = 6;
  localparam int OP_DISCARD = 7;
  localparam logic [1:0] WID_1B = 2'h0;
  localparam logic [1:0] WID_2B = 2'h1;
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_WGUARD = 2'h1;
  localparam logic [1:0] ST_KGUARD = 2'h3;
  localparam logic [BLK_BITS-1:0] ERASED = {BLK_BITS{1'b1}};
  // register map of the controller, word indices taken from bits 4:2 of the byte address
  localparam int RA_W = 3;
  localparam logic [RA_W-1:0] REG_CTRL = 3'h0;
  localparam logic [RA_W-1:0] REG_ADDR = 3'h1;
  localparam logic [RA_W-1:0] REG_WDATA = 3'h2;
  localparam logic [RA_W-1:0] REG_RDATA = 3'h3;
  localparam logic [RA_W-1:0] REG_STATUS = 3'h4;
  localparam logic [RA_W-1:0] REG_IRQ_STAT = 3'h5;
  localparam logic [RA_W-1:0] REG_IRQ_MASK = 3'h6;
  localparam int CTRL_KEEP = 8;
  localparam int CTRL_WGUARD = 9;
  localparam int CTRL_HOLD = 10;
  localparam int CTRL_WIDTH = 12;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_REFUSED = 1;
  localparam int IRQ_W = 2;
endpackage : flash_pkg
